// >>> common/mio_read_pkg.sv
// constants, opcodes and states for the multi-lane buffer read path
package mio_read_pkg;
  localparam int COL_W = 16;
  localparam int BUF_BYTES_DEF = 2176;
  localparam int DUMMY_SHORT_DEF = 8;
  localparam int DUMMY_LONG_DEF = 24;
  localparam logic [7:0] OP_QUAD_OUT_4B = 8'h6C;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO_4B = 8'hBC;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO_4B = 8'hEC;
  localparam logic [5:0] CMD_LAST_BIT = 6'h07;
  localparam logic [5:0] COL_BITS = 6'h10;
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] OE_DUAL = 4'h3;
  localparam logic [3:0] OE_QUAD = 4'hF;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CMD = 6'b000010,
    ST_ADDR = 6'b000100,
    ST_DUMMY = 6'b001000,
    ST_DATA = 6'b010000,
    ST_REJECT = 6'b100000
  } rd_state_t;
endpackage : mio_read_pkg

// >>> common/pin_event_if.sv
// synchronised pin levels and serial clock edges
`timescale 1ns/1ps
`default_nettype none
interface pin_event_if;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_high;
  logic [3:0] io_lvl;
  modport src (output sclk_rise, output sclk_fall, output cs_high, output io_lvl);
  modport dst (input sclk_rise, input sclk_fall, input cs_high, input io_lvl);
endinterface : pin_event_if
`default_nettype wire

// >>> hdl/multi_io_buffer_read.sv
// dual and quad lane buffer read command path
`timescale 1ns/1ps
`default_nettype none
module multi_io_buffer_read #(
  parameter int BUF_BYTES = mio_read_pkg::BUF_BYTES_DEF,
  parameter int DUMMY_SHORT = mio_read_pkg::DUMMY_SHORT_DEF,
  parameter int DUMMY_LONG = mio_read_pkg::DUMMY_LONG_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  input wire logic buf_mode_i,
  input wire logic wp_en_i,
  output logic [mio_read_pkg::COL_W-1:0] buf_addr_o,
  input wire logic [7:0] buf_rdata_i,
  output logic page_next_o
);
  import mio_read_pkg::*;

  localparam logic [COL_W-1:0] LAST_ADDR = COL_W'(BUF_BYTES - 1);

  function automatic logic is_quad(input logic [7:0] op);
    return (op == OP_QUAD_OUT_4B) || (op == OP_QUAD_IO) || (op == OP_QUAD_IO_4B);
  endfunction : is_quad

  function automatic logic is_known(input logic [7:0] op);
    return is_quad(op) || (op == OP_DUAL_IO) || (op == OP_DUAL_IO_4B);
  endfunction : is_known

  function automatic logic [2:0] addr_lanes(input logic [7:0] op);
    if (op == OP_QUAD_OUT_4B) begin
      return LANES_1;
    end else if (is_quad(op)) begin
      return LANES_4;
    end
    return LANES_2;
  endfunction : addr_lanes

  function automatic logic [2:0] data_lanes(input logic [7:0] op);
    return is_quad(op) ? LANES_4 : LANES_2;
  endfunction : data_lanes

  function automatic logic [5:0] dummy_clks(input logic [7:0] op);
    if ((op == OP_QUAD_OUT_4B) || (op == OP_DUAL_IO_4B) || (op == OP_QUAD_IO_4B)) begin
      return 6'(DUMMY_LONG);
    end
    return 6'(DUMMY_SHORT);
  endfunction : dummy_clks

  pin_event_if pins ();

  pin_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .io_i(io_i),
    .pins(pins.src)
  );

  rd_state_t st_q;
  logic [5:0] cnt_q;
  logic [7:0] op_q;
  logic [6:0] cmd_sh_q;
  logic [COL_W-1:0] col_q;
  logic mode_q;
  logic [7:0] sh_q;
  logic [3:0] bits_left_q;
  logic done_q;
  logic [7:0] op_d;
  logic [2:0] alanes;
  logic [2:0] dlanes;
  logic enter_data;

  assign op_d = {cmd_sh_q, pins.io_lvl[0]};
  assign alanes = addr_lanes(op_q);
  assign dlanes = data_lanes(op_q);
  assign enter_data = (st_q == ST_DUMMY) && pins.sclk_rise && !pins.cs_high
                      && (cnt_q == 6'(dummy_clks(op_q) - 6'h01));

  // command framing and input phases, sampled on rising clock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 6'h00;
      op_q <= 8'h00;
      cmd_sh_q <= 7'h00;
      col_q <= '0;
      mode_q <= 1'b0;
    end else if (pins.cs_high) begin
      st_q <= ST_IDLE;
      cnt_q <= 6'h00;
    end else begin
      case (st_q)
        ST_IDLE: begin
          st_q <= ST_CMD;
          cnt_q <= 6'h00;
          mode_q <= buf_mode_i;
        end
        ST_CMD: begin
          if (pins.sclk_rise) begin
            cmd_sh_q <= op_d[6:0];
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == CMD_LAST_BIT) begin
              op_q <= op_d;
              cnt_q <= 6'h00;
              col_q <= '0;
              if (!is_known(op_d) || (wp_en_i && is_quad(op_d))) begin
                st_q <= ST_REJECT;
              end else begin
                st_q <= ST_ADDR;
              end
            end
          end
        end
        ST_ADDR: begin
          if (pins.sclk_rise) begin
            case (alanes)
              LANES_1: col_q <= {col_q[COL_W-2:0], pins.io_lvl[0]};
              LANES_2: col_q <= {col_q[COL_W-3:0], pins.io_lvl[1:0]};
              default: col_q <= {col_q[COL_W-5:0], pins.io_lvl};
            endcase
            cnt_q <= cnt_q + 6'(alanes);
            if (6'(cnt_q + 6'(alanes)) == COL_BITS) begin
              st_q <= ST_DUMMY;
              cnt_q <= 6'h00;
            end
          end
        end
        ST_DUMMY: begin
          if (pins.sclk_rise) begin
            cnt_q <= cnt_q + 6'h01;
            if (enter_data) begin
              st_q <= ST_DATA;
            end
          end
        end
        ST_DATA: st_q <= ST_DATA;
        ST_REJECT: st_q <= ST_REJECT;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // data phase, driven on falling clock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
      buf_addr_o <= '0;
      sh_q <= 8'h00;
      bits_left_q <= 4'h0;
      done_q <= 1'b0;
      page_next_o <= 1'b0;
    end else begin
      page_next_o <= 1'b0;
      if (pins.cs_high || (st_q != ST_DATA && !enter_data)) begin
        io_oe_o <= 4'h0;
        done_q <= 1'b0;
      end else if (enter_data) begin
        buf_addr_o <= mode_q ? col_q : '0;
        bits_left_q <= 4'h0;
        done_q <= mode_q && (col_q > LAST_ADDR);
      end else if (pins.sclk_fall) begin
        if (done_q && (bits_left_q == 4'h0)) begin
          io_oe_o <= 4'h0;
        end else if (bits_left_q == 4'h0) begin
          io_oe_o <= (dlanes == LANES_4) ? OE_QUAD : OE_DUAL;
          if (dlanes == LANES_4) begin
            io_o <= buf_rdata_i[7:4];
            sh_q <= {buf_rdata_i[3:0], 4'h0};
          end else begin
            io_o <= {2'b00, buf_rdata_i[7:6]};
            sh_q <= {buf_rdata_i[5:0], 2'b00};
          end
          bits_left_q <= BYTE_BITS - 4'(dlanes);
          if (buf_addr_o == LAST_ADDR) begin
            if (mode_q) begin
              done_q <= 1'b1;
            end else begin
              buf_addr_o <= '0;
              page_next_o <= 1'b1;
            end
          end else begin
            buf_addr_o <= buf_addr_o + 1'b1;
          end
        end else begin
          if (dlanes == LANES_4) begin
            io_o <= sh_q[7:4];
            sh_q <= {sh_q[3:0], 4'h0};
          end else begin
            io_o <= {2'b00, sh_q[7:6]};
            sh_q <= {sh_q[5:0], 2'b00};
          end
          bits_left_q <= bits_left_q - 4'(dlanes);
        end
      end
    end
  end

  a_quad_lanes: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (io_oe_o != 4'h0 && is_quad(op_q)) |-> io_oe_o == OE_QUAD)
    else $error("quad command not driving four lanes");

  a_dual_lanes: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (io_oe_o != 4'h0 && !is_quad(op_q)) |-> io_oe_o == OE_DUAL)
    else $error("dual command not driving two lanes");

  a_buf_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (enter_data && mode_q) |=> buf_addr_o == $past(col_q))
    else $error("buffer mode did not start at column");

  a_seq_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (enter_data && !mode_q) |=> buf_addr_o == '0)
    else $error("sequential mode did not start at zero");

  a_end_float: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (done_q && pins.sclk_fall && st_q == ST_DATA && bits_left_q == 4'h0) |=> io_oe_o == 4'h0)
    else $error("lines driven past buffer end");

  a_seq_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    page_next_o |-> (buf_addr_o == '0 && !mode_q && st_q == ST_DATA))
    else $error("page roll outside sequential read");

  a_wp_reject: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st_q == ST_CMD && pins.sclk_rise && !pins.cs_high && cnt_q == CMD_LAST_BIT
     && wp_en_i && is_quad(op_d)) |=> (st_q == ST_REJECT) [*2])
    else $error("quad opcode accepted under write protect");

  a_cs_ends: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pins.cs_high |=> (io_oe_o == 4'h0 && st_q == ST_IDLE))
    else $error("command not ended by chip select");

  a_fall_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (io_oe_o != 4'h0 && $changed(io_o)) |-> $past(pins.sclk_fall))
    else $error("data changed off the falling edge");

  a_no_early_oe: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st_q != ST_DATA) |=> io_oe_o == 4'h0)
    else $error("lines driven before data phase");
endmodule : multi_io_buffer_read
`default_nettype wire

// >>> hdl/pin_sync.sv
// three-stage pin synchroniser with clock edge detection
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  pin_event_if.src pins
);
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;
  logic [5:0] lvl_q;
  logic [5:0] lvl_d;
  logic rise_q;
  logic fall_q;

  // a bit moves only when stages two and three agree
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : lvl_q[i];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 6'h20;
      s2_q <= 6'h20;
      s3_q <= 6'h20;
      lvl_q <= 6'h20;
    end else begin
      s1_q <= {cs_n_i, sclk_i, io_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= lvl_d[4] & ~lvl_q[4];
      fall_q <= ~lvl_d[4] & lvl_q[4];
    end
  end

  assign pins.sclk_rise = rise_q;
  assign pins.sclk_fall = fall_q;
  assign pins.cs_high = lvl_q[5];
  assign pins.io_lvl = lvl_q[3:0];
endmodule : pin_sync
`default_nettype wire

// >>> verif/multi_io_buffer_read_test.sv
// testbench for the multi-lane buffer read path
`timescale 1ns/1ps
`default_nettype none
module multi_io_buffer_read_test;
  import mio_read_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic buf_mode_i = 1'b1;
  logic wp_en_i = 1'b0;
  logic [3:0] io_o;
  logic [3:0] io_oe_o;
  logic [3:0] h_io;
  logic [3:0] io_w;
  logic sclk;
  logic cs_n;
  logic [15:0] buf_addr_o;
  logic page_next_o;
  logic [7:0] buf_rdata;
  logic [3:0] pg = 4'h0;
  int err_total = 0;
  int checks = 0;
  logic [7:0] ops [5] = '{OP_QUAD_OUT_4B, OP_DUAL_IO, OP_DUAL_IO_4B, OP_QUAD_IO, OP_QUAD_IO_4B};
  int al [5] = '{1, 2, 2, 4, 4};
  int dm [5] = '{8, 4, 8, 4, 8};
  int dl [5] = '{4, 2, 2, 4, 4};
  always #2.5 core_clk_i = ~core_clk_i;
  assign io_w = (io_oe_o & io_o) | (~io_oe_o & h_io);
  assign buf_rdata = 8'h96 ^ {pg, buf_addr_o[3:0]};
  always_ff @(posedge core_clk_i) if (page_next_o === 1'b1) pg <= pg + 4'h1;
  multi_io_buffer_read #(.BUF_BYTES(8), .DUMMY_SHORT(4), .DUMMY_LONG(8)) DUT (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_w), .io_o(io_o),
    .io_oe_o(io_oe_o), .buf_mode_i(buf_mode_i), .wp_en_i(wp_en_i), .buf_addr_o(buf_addr_o),
    .buf_rdata_i(buf_rdata), .page_next_o(page_next_o)
  );
  spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(h_io), .io_i(io_w), .oe_i(io_oe_o));
  function automatic logic [7:0] fv(input logic [3:0] p, input int a);
    return 8'h96 ^ {p, 4'(a)};
  endfunction : fv
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic set_mode(input logic bm, input logic wp);
    @(posedge core_clk_i);
    #1 buf_mode_i = bm;
    wp_en_i = wp;
  endtask : set_mode
  // buffer mode from column 5 to the end, then floating
  task automatic t_buffer_all;
    set_mode(1'b1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      host.xfer(ops[i], 16'h0005, al[i], dm[i], dl[i], 4);
      for (int k = 0; k < 3; k++) begin
        check("buf byte", fv(pg, 5 + k), host.rx[k]);
        check("buf oe", {4'h0, (dl[i] == 4) ? OE_QUAD : OE_DUAL}, {4'h0, host.rxoe[k]});
      end
      check("oe after end", 8'h00, {4'h0, host.rxoe[3]});
    end
  endtask : t_buffer_all
  // sequential mode ignores column and rolls into next page
  task automatic t_seq_roll;
    logic [3:0] p0;
    set_mode(1'b0, 1'b0);
    p0 = pg;
    host.xfer(OP_QUAD_IO, 16'h0003, 4, 4, 4, 10);
    for (int k = 0; k < 10; k++) check("seq byte", fv((k < 8) ? p0 : p0 + 4'h1, k % 8), host.rx[k]);
    check("page count", {4'h0, p0 + 4'h1}, {4'h0, pg});
  endtask : t_seq_roll
  // write-protect enable blocks quad opcodes only
  task automatic t_wp_reject;
    set_mode(1'b1, 1'b1);
    for (int i = 0; i < 5; i++) begin
      host.xfer(ops[i], 16'h0002, al[i], dm[i], dl[i], 1);
      check("wp oe", {4'h0, (i == 1 || i == 2) ? OE_DUAL : 4'h0}, {4'h0, host.rxoe[0]});
    end
  endtask : t_wp_reject
  // chip select high in mid-stream ends the drive
  task automatic t_abort;
    set_mode(1'b1, 1'b0);
    host.xfer(OP_QUAD_IO_4B, 16'h0000, 4, 8, 4, 1);
    check("abort byte", fv(pg, 0), host.rx[0]);
    check("abort oe", 8'h00, {4'h0, io_oe_o});
  endtask : t_abort
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge core_clk_i);
    #1;
    check("reset oe", 8'h00, {4'h0, io_oe_o});
    check("reset addr", 8'h00, buf_addr_o[7:0]);
    rst_n_i = 1'b1;
    repeat (6) @(posedge core_clk_i);
    t_buffer_all();
    t_seq_roll();
    t_wp_reject();
    t_abort();
    give_verdict();
  end
endmodule : multi_io_buffer_read_test
`default_nettype wire

// >>> verif/spi_host_model.sv
// serial host that frames commands and collects returned bytes
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  input wire logic [3:0] io_i,
  input wire logic [3:0] oe_i
);
  logic [7:0] rx [16];
  logic [3:0] rxoe [16];
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
  end
  // one clock: set lines after fall, sample just before the next fall
  task automatic clk_bit(input logic [3:0] v, input logic drive, output logic [3:0] s, output logic [3:0] so);
    io_o = drive ? v : ~io_o;
    #24 sclk_o = 1'b1;
    #23 s = io_i;
    so = oe_i;
    #1 sclk_o = 1'b0;
  endtask : clk_bit
  task automatic xfer(input logic [7:0] op, input logic [15:0] col, input int al, input int dmy, input int dl,
                      input int n);
    logic [3:0] s;
    logic [3:0] so;
    logic [7:0] b;
    b = 8'h00;
    cs_n_o = 1'b0;
    #48;
    for (int i = 7; i >= 0; i--) clk_bit({3'h0, op[i]}, 1'b1, s, so);
    for (int i = 16 / al - 1; i >= 0; i--) clk_bit(4'((col >> (i * al)) & ((1 << al) - 1)), 1'b1, s, so);
    for (int i = 0; i < dmy; i++) clk_bit(4'h0, 1'b0, s, so);
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < 8 / dl; j++) begin
        clk_bit(4'h0, 1'b0, s, so);
        b = 8'((b << dl) | (s & ((1 << dl) - 1)));
      end
      rx[k] = b;
      rxoe[k] = so;
    end
    #24 cs_n_o = 1'b1;
    #96;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire
